// *** src/ricpd_map.svh ***
// Register map, field positions and reset values for the reference block
`ifndef RICPD_MAP_SVH
`define RICPD_MAP_SVH
`define RICPD_OFF_CTL 8'h33
`define RICPD_OFF_ARDIV 8'h34
`define RICPD_OFF_AMDIV 8'h35
`define RICPD_OFF_BRDIV 8'h36
`define RICPD_OFF_BMDIV 8'h37
`define RICPD_OFF_STAT 8'h38
`define RICPD_BIT_SKIP 7
`define RICPD_BIT_KEEP 2
`define RICPD_BIT_AGAIN 1
`define RICPD_BIT_MGAIN 0
`define RICPD_CTL_RST 8'h03
`define RICPD_CTL_MASK 8'hff
`define RICPD_DIV_RST 8'h00
`define RICPD_RDIV_MASK 8'h07
`define RICPD_MDIV_MASK 8'h1f
`define RICPD_ZERO8 8'h00
`define RICPD_ZERO32 32'h0000_0000
`endif

// *** src/ricpd_pkg.sv ***
// Types for the reference input control block
`default_nettype none
package ricpd_pkg;
  typedef enum logic [1:0] {
    RICPD_SEL_MAIN = 2'b00,
    RICPD_STOP_MAIN = 2'b01,
    RICPD_SEL_ALT = 2'b10,
    RICPD_STOP_ALT = 2'b11
  } ricpd_mux_t;
endpackage : ricpd_pkg
`default_nettype wire

// *** src/ricpd_ref_mux.sv ***
// Glitch-free reference source multiplexer with bypass
`default_nettype none
module ricpd_ref_mux
  import ricpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mux_skip,
  input wire logic want_alt,
  input wire logic main_ref,
  input wire logic alt_ref,
  output logic ref_out,
  output logic alt_active
);
  ricpd_mux_t state_q;
  logic ref_q;

  // ***************************
  // Source switch sequence
  // ***************************
  // Stop old then start new
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= RICPD_SEL_MAIN;
    end else if (clk_en) begin
      case (state_q)
        RICPD_SEL_MAIN: begin
          if (want_alt && !ref_q) begin
            state_q <= RICPD_STOP_MAIN;
          end
        end
        RICPD_STOP_MAIN: begin
          if (!alt_ref) begin
            state_q <= RICPD_SEL_ALT;
          end
        end
        RICPD_SEL_ALT: begin
          if (!want_alt && !ref_q) begin
            state_q <= RICPD_STOP_ALT;
          end
        end
        RICPD_STOP_ALT: begin
          if (!main_ref) begin
            state_q <= RICPD_SEL_MAIN;
          end
        end
        default: begin
          state_q <= RICPD_SEL_MAIN;
        end
      endcase
    end
  end

  // ***************************
  // Output clock register
  // ***************************
  // Bypass takes direct source
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_q <= 1'b0;
    end else if (clk_en) begin
      if (mux_skip) begin
        ref_q <= want_alt ? alt_ref : main_ref;
      end else begin
        case (state_q)
          RICPD_SEL_MAIN: ref_q <= main_ref;
          RICPD_SEL_ALT: ref_q <= alt_ref;
          default: ref_q <= 1'b0;
        endcase
      end
    end
  end

  assign ref_out = ref_q;
  assign alt_active = mux_skip ? want_alt :
    (state_q == RICPD_SEL_ALT) || (state_q == RICPD_STOP_MAIN);
endmodule : ricpd_ref_mux
`default_nettype wire

// *** src/ricpd_top.sv ***
// Reference input control and synthesizer pre-divider registers
//
// Implementation choice: the Avalon-MM register port.
`include "ricpd_map.svh"
`default_nettype none
module ricpd_top
  import ricpd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ref_select_alt,
  input wire logic main_ref,
  input wire logic alt_ref,
  output logic ref_clk_out,
  output logic ref_mux_skip,
  output logic alt_xtal_enable,
  output logic alt_buffer_gain,
  output logic main_buffer_gain,
  output logic [2:0] synth_a_pre_div,
  output logic [4:0] synth_a_m_ratio,
  output logic [2:0] synth_b_pre_div,
  output logic [4:0] synth_b_m_ratio
);
  initial begin
    if (ADDR_W < 8) begin
      $error("ADDR_W too small");
    end
  end

  logic [7:0] ctl_q;
  logic [7:0] ardiv_q;
  logic [7:0] amdiv_q;
  logic [7:0] brdiv_q;
  logic [7:0] bmdiv_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic alt_active;
  logic mux_out;
  logic alt_on_q;
  logic [2:0] ra_q;
  logic [4:0] ma_q;
  logic [2:0] rb_q;
  logic [4:0] mb_q;

  // ***************************
  // Address decode
  // ***************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a,
    input logic [7:0] c, input logic [7:0] r1, input logic [7:0] m1,
    input logic [7:0] r2, input logic [7:0] m2, input logic st);
    rd_mux = `RICPD_ZERO32;
    if (hit(a, `RICPD_OFF_CTL)) rd_mux = {24'h00_0000, c};
    if (hit(a, `RICPD_OFF_ARDIV)) rd_mux = {24'h00_0000, r1};
    if (hit(a, `RICPD_OFF_AMDIV)) rd_mux = {24'h00_0000, m1};
    if (hit(a, `RICPD_OFF_BRDIV)) rd_mux = {24'h00_0000, r2};
    if (hit(a, `RICPD_OFF_BMDIV)) rd_mux = {24'h00_0000, m2};
    if (hit(a, `RICPD_OFF_STAT)) rd_mux = {31'h0000_0000, st};
  endfunction : rd_mux

  logic req;
  logic wr_go;
  assign req = (avs_read || avs_write) && !ack_q;
  // Write lands at the edge that sees waitrequest low
  assign wr_go = avs_write && ack_q && avs_byteenable[0];

  // ***************************
  // Bus handshake
  // ***************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else if (clk_en) begin
      ack_q <= req;
      wait_q <= !req;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `RICPD_ZERO32;
    end else if (clk_en) begin
      if (avs_read && !ack_q) begin
        rdata_q <= rd_mux(avs_address, ctl_q, ardiv_q, amdiv_q, brdiv_q,
                          bmdiv_q, alt_on_q);
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ***************************
  // Register writes
  // ***************************
  // Skip bit resets to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= `RICPD_CTL_RST;
    end else if (clk_en && wr_go && hit(avs_address, `RICPD_OFF_CTL)) begin
      ctl_q <= avs_writedata[7:0] & `RICPD_CTL_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ardiv_q <= `RICPD_DIV_RST;
    end else if (clk_en && wr_go && hit(avs_address, `RICPD_OFF_ARDIV)) begin
      ardiv_q <= avs_writedata[7:0] & `RICPD_RDIV_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      amdiv_q <= `RICPD_DIV_RST;
    end else if (clk_en && wr_go && hit(avs_address, `RICPD_OFF_AMDIV)) begin
      amdiv_q <= avs_writedata[7:0] & `RICPD_MDIV_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      brdiv_q <= `RICPD_DIV_RST;
    end else if (clk_en && wr_go && hit(avs_address, `RICPD_OFF_BRDIV)) begin
      brdiv_q <= avs_writedata[7:0] & `RICPD_RDIV_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bmdiv_q <= `RICPD_DIV_RST;
    end else if (clk_en && wr_go && hit(avs_address, `RICPD_OFF_BMDIV)) begin
      bmdiv_q <= avs_writedata[7:0] & `RICPD_MDIV_MASK;
    end
  end

  // ***************************
  // Reference multiplexer
  // ***************************
  // Glitch-free source change
  ricpd_ref_mux u_mux (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .mux_skip(ctl_q[`RICPD_BIT_SKIP]),
    .want_alt(ref_select_alt),
    .main_ref(main_ref),
    .alt_ref(alt_ref),
    .ref_out(mux_out),
    .alt_active(alt_active)
  );

  // ***************************
  // Alternate crystal power
  // ***************************
  // Off after return to main unless the keep bit is set
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alt_on_q <= 1'b0;
    end else if (clk_en) begin
      if (alt_active) begin
        alt_on_q <= 1'b1;
      end else if (!ctl_q[`RICPD_BIT_KEEP]) begin
        alt_on_q <= 1'b0;
      end
    end
  end

  // ***************************
  // Registered outputs
  // ***************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ra_q <= 3'h0;
      ma_q <= 5'h00;
      rb_q <= 3'h0;
      mb_q <= 5'h00;
    end else if (clk_en) begin
      ra_q <= ardiv_q[2:0];
      ma_q <= amdiv_q[4:0];
      rb_q <= brdiv_q[2:0];
      mb_q <= bmdiv_q[4:0];
    end
  end

  assign ref_clk_out = mux_out;
  assign alt_xtal_enable = alt_on_q;
  assign ref_mux_skip = ctl_q[`RICPD_BIT_SKIP];
  assign alt_buffer_gain = ctl_q[`RICPD_BIT_AGAIN];
  assign main_buffer_gain = ctl_q[`RICPD_BIT_MGAIN];
  assign synth_a_pre_div = ra_q;
  assign synth_a_m_ratio = ma_q;
  assign synth_b_pre_div = rb_q;
  assign synth_b_m_ratio = mb_q;
endmodule : ricpd_top
`default_nettype wire

// *** bench/ricpd_top_properties.sv ***
// Port checks for the reference control block
`include "ricpd_map.svh"
`default_nettype none
module ricpd_top_chk
  import ricpd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic ref_select_alt,
  input wire logic ref_mux_skip,
  input wire logic alt_xtal_enable,
  input wire logic alt_buffer_gain,
  input wire logic main_buffer_gain,
  input wire logic [2:0] synth_a_pre_div,
  input wire logic [4:0] synth_a_m_ratio,
  input wire logic [2:0] synth_b_pre_div,
  input wire logic [4:0] synth_b_m_ratio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk, wr;
  logic [7:0] ad, ctl_q, d;
  logic [2:0] ra_q, rb_q;
  logic [4:0] ma_q, mb_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Register mirror
  // ****************************************
  assign ad = avs_address[7:0];
  assign d = avs_writedata[7:0];
  assign tk = (avs_read | avs_write) & avs_waitrequest & clk_en;
  assign wr = avs_write & !avs_waitrequest & clk_en & avs_byteenable[0];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= `RICPD_CTL_RST;
      ra_q <= 3'h0;
      ma_q <= 5'h00;
      rb_q <= 3'h0;
      mb_q <= 5'h00;
    end else if (wr) begin
      case (ad)
        `RICPD_OFF_CTL: ctl_q <= d;
        `RICPD_OFF_ARDIV: ra_q <= d[2:0];
        `RICPD_OFF_AMDIV: ma_q <= d[4:0];
        `RICPD_OFF_BRDIV: rb_q <= d[2:0];
        `RICPD_OFF_BMDIV: mb_q <= d[4:0];
        default: ;
      endcase
    end
  end
  chk_skip_bit:
    assert property (ref_mux_skip == ctl_q[7]) else $error("skip bit");
  chk_alt_gain:
    assert property (alt_buffer_gain == ctl_q[1]) else $error("alt gain");
  chk_main_gain:
    assert property (main_buffer_gain == ctl_q[0]) else $error("main gain");
  chk_keep_off:
    assert property ((!ctl_q[2] && !ref_select_alt)[*8] |-> !alt_xtal_enable)
    else $error("xtal left on");
  chk_keep_on:
    assert property (ctl_q[2] && alt_xtal_enable ##1 ctl_q[2]
      |-> alt_xtal_enable) else $error("xtal dropped");
  chk_a_pre:
    assert property (synth_a_pre_div == $past(ra_q)) else $error("a pre");
  chk_a_ratio:
    assert property (synth_a_m_ratio == $past(ma_q)) else $error("a m");
  chk_b_pre:
    assert property (synth_b_pre_div == $past(rb_q)) else $error("b pre");
  chk_b_ratio:
    assert property (synth_b_m_ratio == $past(mb_q)) else $error("b m");
  chk_bus_answer:
    assert property (tk |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer");
  cover property (wr && ad == `RICPD_OFF_CTL);
  cover property ($fell(alt_xtal_enable));
  cover property (!avs_waitrequest && avs_read);
endmodule : ricpd_top_chk
`default_nettype wire

// *** bench/tb_ricpd_top.sv ***
// Self-checking bench for the reference control block
`include "ricpd_map.svh"
`default_nettype none
module tb_ricpd_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, rd = 0, wr = 0, sel = 0, mr = 0, ar = 0;
  logic wq, sk, ax, ag, mg;
  logic [7:0] ad = 0;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 0, q, rdat;
  logic [2:0] ap, bp;
  logic [4:0] am, bm;
  int num_errors = 0, total_checks = 0, cyc = 0;
  ricpd_top u_dut (
    .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .avs_address(ad),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .ref_select_alt(sel), .main_ref(mr), .alt_ref(ar), .ref_clk_out(),
    .ref_mux_skip(sk), .alt_xtal_enable(ax), .alt_buffer_gain(ag),
    .main_buffer_gain(mg), .synth_a_pre_div(ap), .synth_a_m_ratio(am),
    .synth_b_pre_div(bp), .synth_b_m_ratio(bm)
  );
  // ****************************************
  // Clock, references and watchdog
  // ****************************************
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    mr <= ~mr;
    if (cyc[0]) ar <= ~ar;
    if (cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    ad <= a;
    wd <= {24'h00_0000, d};
    wr <= w;
    rd <= !w;
    do @(posedge core_clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic rc(logic [7:0] a, logic [7:0] e);
    bus(0, a, 8'h00);
    chk("readdata", e, q);
  endtask : rc
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_rst;
    rc(`RICPD_OFF_CTL, 8'h03);
    rc(`RICPD_OFF_ARDIV, 8'h00);
    rc(`RICPD_OFF_AMDIV, 8'h00);
    rc(`RICPD_OFF_BRDIV, 8'h00);
    rc(`RICPD_OFF_BMDIV, 8'h00);
    chk("pins", 3'b011, {sk, ag, mg});
  endtask : t_rst
  task automatic t_ctl;
    bus(1, `RICPD_OFF_CTL, 8'h84);
    rc(`RICPD_OFF_CTL, 8'h84);
    chk("pins", 3'b100, {sk, ag, mg});
  endtask : t_ctl
  task automatic t_div;
    for (int i = 4; i < 8; i++) bus(1, 8'h30 + 8'(i), 8'hff);
    rc(`RICPD_OFF_ARDIV, 8'h07);
    rc(`RICPD_OFF_AMDIV, 8'h1f);
    rc(`RICPD_OFF_BRDIV, 8'h07);
    rc(`RICPD_OFF_BMDIV, 8'h1f);
    chk("divs", 16'hffff, {bm, bp, am, ap});
    for (int i = 4; i < 8; i++) bus(1, 8'h30 + 8'(i), 8'h01);
    rc(`RICPD_OFF_ARDIV, 8'h01);
    chk("divs", 16'h0909, {bm, bp, am, ap});
  endtask : t_div
  task automatic t_bad;
    be <= 4'h0;
    bus(1, `RICPD_OFF_ARDIV, 8'h05);
    be <= 4'hf;
    rc(`RICPD_OFF_ARDIV, 8'h01);
    bus(1, 8'h40, 8'hff);
    rc(8'h40, 8'h00);
  endtask : t_bad
  task automatic t_keep;
    for (int k = 0; k < 2; k++) begin
      bus(1, `RICPD_OFF_CTL, {5'h00, k[0], 2'b11});
      sel <= 1;
      repeat (20) @(posedge core_clk);
      chk("xtal on", 1, ax);
      sel <= 0;
      repeat (20) @(posedge core_clk);
      chk("xtal after", k[0], ax);
      rc(`RICPD_OFF_STAT, {7'h00, k[0]});
    end
  endtask : t_keep
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    t_rst;
    t_ctl;
    t_div;
    t_bad;
    t_keep;
    conclude;
  end
endmodule : tb_ricpd_top
bind ricpd_top ricpd_top_chk #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .ref_select_alt(ref_select_alt),
  .ref_mux_skip(ref_mux_skip), .alt_xtal_enable(alt_xtal_enable),
  .alt_buffer_gain(alt_buffer_gain), .main_buffer_gain(main_buffer_gain),
  .synth_a_pre_div(synth_a_pre_div), .synth_a_m_ratio(synth_a_m_ratio),
  .synth_b_pre_div(synth_b_pre_div), .synth_b_m_ratio(synth_b_m_ratio)
);
`default_nettype wire
